// [design/tap_pkg.sv]
// tap_pkg: constants, encodings and state records for the boundary-scan test port logic.
// assumes a 250 MHz system clock and a free-standing test clock from an outside scan controller.
package tap_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int unsigned IR_W          = 4;
   localparam int unsigned ID_W          = 32;
   localparam int unsigned NUM_PINS      = 8;
   localparam int unsigned CELLS_PER_PIN = 4;
   localparam int unsigned ANA_W         = 4;
   localparam int unsigned ANA_BASE      = NUM_PINS * CELLS_PER_PIN;
   localparam int unsigned ANA_OBS_BASE  = ANA_BASE + ANA_W;
   localparam int unsigned CHAIN_W       = ANA_OBS_BASE + ANA_W;
   localparam int unsigned TOUT_W        = 24;

   // ----------------------------------------------------------------
   // boundary cell positions inside one pin group
   // ----------------------------------------------------------------
   localparam int unsigned CELL_ID  = 0;
   localparam int unsigned CELL_OD  = 1;
   localparam int unsigned CELL_OC  = 2;
   localparam int unsigned CELL_PUE = 3;

   // ----------------------------------------------------------------
   // instruction codes
   // ----------------------------------------------------------------
   localparam logic [IR_W-1:0] OP_EXTEST     = 4'h0;
   localparam logic [IR_W-1:0] OP_IDCODE     = 4'h1;
   localparam logic [IR_W-1:0] OP_SAMPLE     = 4'h2;
   localparam logic [IR_W-1:0] OP_CHIP_RESET = 4'hC;
   localparam logic [IR_W-1:0] OP_BYPASS     = 4'hF;
   localparam logic [IR_W-1:0] IR_CAPTURE    = 4'h1;

   // ----------------------------------------------------------------
   // identification fields (values arbitrary)
   // ----------------------------------------------------------------
   localparam logic [3:0]  ID_VERSION  = 4'h0;
   localparam logic [15:0] ID_PART     = 16'h5A5A;
   localparam logic [10:0] ID_MAKER    = 11'h2A6;
   localparam logic        ID_LSB      = 1'b1;

   // ----------------------------------------------------------------
   // reset time-out after the test reset bit clears
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned TOUT_FAST_NS  = 4_100_000;
   localparam int unsigned TOUT_SLOW_NS  = 65_000_000;
   localparam int unsigned TOUT_FAST_CYC = (TOUT_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TOUT_SLOW_CYC = (TOUT_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // controller states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      TAP_RESET   = 4'h0,
      TAP_IDLE    = 4'h1,
      TAP_SEL_DR  = 4'h2,
      TAP_CAP_DR  = 4'h3,
      TAP_SH_DR   = 4'h4,
      TAP_EX1_DR  = 4'h5,
      TAP_PAU_DR  = 4'h6,
      TAP_EX2_DR  = 4'h7,
      TAP_UPD_DR  = 4'h8,
      TAP_SEL_IR  = 4'h9,
      TAP_CAP_IR  = 4'hA,
      TAP_SH_IR   = 4'hB,
      TAP_EX1_IR  = 4'hC,
      TAP_PAU_IR  = 4'hD,
      TAP_EX2_IR  = 4'hE,
      TAP_UPD_IR  = 4'hF
   } tap_state_t;

   // ----------------------------------------------------------------
   // state records
   // ----------------------------------------------------------------
   typedef struct packed {
      logic               por_s1;
      logic               por_s2;
      logic               fuse_s1;
      logic               fuse_s2;
      logic               dis_s1;
      logic               dis_s2;
      logic [CHAIN_W-1:0] cap_s1;
      logic [CHAIN_W-1:0] cap_s2;
      tap_state_t         tap;
      logic [IR_W-1:0]    ir_sh;
      logic [IR_W-1:0]    ir;
      logic               byp;
      logic [ID_W-1:0]    id_sh;
      logic               rst_bit;
      logic [CHAIN_W-1:0] bs_sh;
      logic [CHAIN_W-1:0] bs_upd;
   } tck_state_t;

   typedef struct packed {
      logic              rst_s1;
      logic              rst_s2;
      logic              busy;
      logic [TOUT_W-1:0] cnt;
   } sys_state_t;

   typedef struct packed {
      logic [NUM_PINS-1:0] dout;
      logic [NUM_PINS-1:0] oe;
      logic [NUM_PINS-1:0] pue;
   } pin_drive_t;

endpackage

// [design/boundary_scan_tap_logic.sv]
// boundary_scan_tap_logic: test port controller, instruction and data registers, boundary chain
// and the chip-reset hold with its time-out.
// assumes tms/tdi change on the falling test clock and are sampled on its rising edge here.
`timescale 1ns/10ps

// How it works
// - instruction register is four bits wide, sixteen codes decodable.
// - every shift path moves least significant bit first in and out.
// - code 0x0 puts the boundary chain, pin and analog cells, between tdi and tdo.
// - once that code is loaded, output latches drive the pins at once.
// - chain-selecting codes capture pin levels in capture-dr, shift in shift-dr.
// - under code 0x0, update-dr moves shifted chain to the output pins.
// - code 0x1 selects 32-bit identification register, captured then shifted.
// - after power-up and controller reset the instruction is the identification code.
// - identification holds a 4-bit version field counting silicon revisions from zero.
// - identification also holds fixed part number and maker fields.
// - code 0x2 selects the chain; update loads latches without touching pins.
// - code 0xC selects one-bit reset register, shift only, controller unaffected.
// - chip held in reset while reset bit is one, with no latch delay.
// - after bit clears, reset stays for a time-out chosen by clock configuration.
// - entering reset puts port outputs into high impedance immediately, except under code 0x0, where the latches keep driving.
// - no high-impedance instruction; tri-state comes from the chip-reset instruction.
// - code 0xF selects one-stage bypass, loaded with zero in capture-dr.
// - port works only with enable fuse programmed and disable bit clear.
// - scan works with chip clock stopped and test clock faster than it.
// - five test clocks with tms high reach test-logic-reset from any state.
module boundary_scan_tap_logic #(
   parameter int unsigned TOUT_FAST_CYC = tap_pkg::TOUT_FAST_CYC,
   parameter int unsigned TOUT_SLOW_CYC = tap_pkg::TOUT_SLOW_CYC
) (
   // system clock and reset
   input  wire logic                         clk_in,
   input  wire logic                         reset_in,
   // chip configuration
   input  wire logic                         tap_enable_fuse_in,
   input  wire logic                         tap_disable_bit_in,
   input  wire logic                         clk_config_in,
   // test access port
   input  wire logic                         tck_in,
   input  wire logic                         tms_in,
   input  wire logic                         tdi_in,
   output logic                              tdo_out,
   output logic                              tdo_oe_out,
   // system side of the port pins and analog interface
   input  wire tap_pkg::pin_drive_t          sys_pins_in,
   input  wire logic [tap_pkg::ANA_W-1:0]    sys_ana_ctl_in,
   // port pins
   input  wire logic [tap_pkg::NUM_PINS-1:0] port_pin_in,
   output tap_pkg::pin_drive_t               port_pins_out,
   // analog interface
   input  wire logic [tap_pkg::ANA_W-1:0]    ana_obs_in,
   output logic [tap_pkg::ANA_W-1:0]         ana_ctl_out,
   // chip reset
   output logic                              chip_reset_out
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   tap_pkg::tck_state_t           t_q;
   tap_pkg::tck_state_t           t_d;
   tap_pkg::sys_state_t           s_q;
   tap_pkg::sys_state_t           s_d;
   logic [tap_pkg::CHAIN_W-1:0]   cap_raw;
   logic [tap_pkg::ID_W-1:0]      id_value;
   logic                          extest_on;
   logic                          in_reset;
   logic                          sel_chain;
   logic                          sel_id;
   logic                          sel_rst;
   logic                          tap_on;
   logic [tap_pkg::TOUT_W-1:0]    tout_sel;

   assign id_value = {tap_pkg::ID_VERSION,
                      tap_pkg::ID_PART,
                      tap_pkg::ID_MAKER,
                      tap_pkg::ID_LSB};

   // ----------------------------------------------------------------
   // instruction decode
   // ----------------------------------------------------------------
   always_comb begin
      sel_chain = 1'b0;
      sel_id    = 1'b0;
      sel_rst   = 1'b0;
      unique case (t_q.ir)
         tap_pkg::OP_EXTEST,
         tap_pkg::OP_SAMPLE:     sel_chain = 1'b1;
         tap_pkg::OP_IDCODE:     sel_id    = 1'b1;
         tap_pkg::OP_CHIP_RESET: sel_rst   = 1'b1;
         default:                sel_chain = 1'b0;
      endcase
   end

   assign extest_on = (t_q.ir == tap_pkg::OP_EXTEST);
   assign tap_on    = t_q.fuse_s2 & ~t_q.dis_s2;

   // ----------------------------------------------------------------
   // pins: boundary latches under extest, tri-state in reset
   // ----------------------------------------------------------------
   assign in_reset       = chip_reset_out | reset_in;
   assign chip_reset_out = t_q.rst_bit | s_q.busy;

   always_comb begin
      for (int i = 0; i < tap_pkg::NUM_PINS; i++) begin
         if (extest_on) begin
            port_pins_out.dout[i] = t_q.bs_upd[i*tap_pkg::CELLS_PER_PIN + tap_pkg::CELL_OD];
            port_pins_out.oe[i]   = t_q.bs_upd[i*tap_pkg::CELLS_PER_PIN + tap_pkg::CELL_OC];
            port_pins_out.pue[i]  = t_q.bs_upd[i*tap_pkg::CELLS_PER_PIN + tap_pkg::CELL_PUE];
         end else if (in_reset) begin
            port_pins_out.dout[i] = 1'b0;
            port_pins_out.oe[i]   = 1'b0;
            port_pins_out.pue[i]  = 1'b0;
         end else begin
            port_pins_out.dout[i] = sys_pins_in.dout[i];
            port_pins_out.oe[i]   = sys_pins_in.oe[i];
            port_pins_out.pue[i]  = sys_pins_in.pue[i];
         end
      end
      for (int j = 0; j < tap_pkg::ANA_W; j++) begin
         ana_ctl_out[j] = extest_on ? t_q.bs_upd[tap_pkg::ANA_BASE + j] : sys_ana_ctl_in[j];
      end
   end

   // ----------------------------------------------------------------
   // capture vector, synchronised into the test clock domain
   // ----------------------------------------------------------------
   always_comb begin
      cap_raw = '0;
      for (int i = 0; i < tap_pkg::NUM_PINS; i++) begin
         cap_raw[i*tap_pkg::CELLS_PER_PIN + tap_pkg::CELL_ID]  = port_pin_in[i];
         cap_raw[i*tap_pkg::CELLS_PER_PIN + tap_pkg::CELL_OD]  = port_pins_out.dout[i];
         cap_raw[i*tap_pkg::CELLS_PER_PIN + tap_pkg::CELL_OC]  = port_pins_out.oe[i];
         cap_raw[i*tap_pkg::CELLS_PER_PIN + tap_pkg::CELL_PUE] = port_pins_out.pue[i];
      end
      for (int j = 0; j < tap_pkg::ANA_W; j++) begin
         cap_raw[tap_pkg::ANA_BASE + j]     = ana_ctl_out[j];
         cap_raw[tap_pkg::ANA_OBS_BASE + j] = ana_obs_in[j];
      end
   end

   // ----------------------------------------------------------------
   // test clock domain
   // ----------------------------------------------------------------
   always_comb begin
      t_d         = t_q;
      t_d.por_s1  = reset_in;
      t_d.por_s2  = t_q.por_s1;
      t_d.fuse_s1 = tap_enable_fuse_in;
      t_d.fuse_s2 = t_q.fuse_s1;
      t_d.dis_s1  = tap_disable_bit_in;
      t_d.dis_s2  = t_q.dis_s1;
      t_d.cap_s1  = cap_raw;
      t_d.cap_s2  = t_q.cap_s1;

      // controller walk; tms high for five clocks always ends in reset
      unique case (t_q.tap)
         tap_pkg::TAP_RESET:  t_d.tap = tms_in ? tap_pkg::TAP_RESET  : tap_pkg::TAP_IDLE;
         tap_pkg::TAP_IDLE:   t_d.tap = tms_in ? tap_pkg::TAP_SEL_DR : tap_pkg::TAP_IDLE;
         tap_pkg::TAP_SEL_DR: t_d.tap = tms_in ? tap_pkg::TAP_SEL_IR : tap_pkg::TAP_CAP_DR;
         tap_pkg::TAP_CAP_DR: t_d.tap = tms_in ? tap_pkg::TAP_EX1_DR : tap_pkg::TAP_SH_DR;
         tap_pkg::TAP_SH_DR:  t_d.tap = tms_in ? tap_pkg::TAP_EX1_DR : tap_pkg::TAP_SH_DR;
         tap_pkg::TAP_EX1_DR: t_d.tap = tms_in ? tap_pkg::TAP_UPD_DR : tap_pkg::TAP_PAU_DR;
         tap_pkg::TAP_PAU_DR: t_d.tap = tms_in ? tap_pkg::TAP_EX2_DR : tap_pkg::TAP_PAU_DR;
         tap_pkg::TAP_EX2_DR: t_d.tap = tms_in ? tap_pkg::TAP_UPD_DR : tap_pkg::TAP_SH_DR;
         tap_pkg::TAP_UPD_DR: t_d.tap = tms_in ? tap_pkg::TAP_SEL_DR : tap_pkg::TAP_IDLE;
         tap_pkg::TAP_SEL_IR: t_d.tap = tms_in ? tap_pkg::TAP_RESET  : tap_pkg::TAP_CAP_IR;
         tap_pkg::TAP_CAP_IR: t_d.tap = tms_in ? tap_pkg::TAP_EX1_IR : tap_pkg::TAP_SH_IR;
         tap_pkg::TAP_SH_IR:  t_d.tap = tms_in ? tap_pkg::TAP_EX1_IR : tap_pkg::TAP_SH_IR;
         tap_pkg::TAP_EX1_IR: t_d.tap = tms_in ? tap_pkg::TAP_UPD_IR : tap_pkg::TAP_PAU_IR;
         tap_pkg::TAP_PAU_IR: t_d.tap = tms_in ? tap_pkg::TAP_EX2_IR : tap_pkg::TAP_PAU_IR;
         tap_pkg::TAP_EX2_IR: t_d.tap = tms_in ? tap_pkg::TAP_UPD_IR : tap_pkg::TAP_SH_IR;
         tap_pkg::TAP_UPD_IR: t_d.tap = tms_in ? tap_pkg::TAP_SEL_DR : tap_pkg::TAP_IDLE;
      endcase

      // register actions in the state being left on this edge
      unique case (t_q.tap)
         tap_pkg::TAP_RESET: begin
            t_d.ir = tap_pkg::OP_IDCODE;
         end
         tap_pkg::TAP_CAP_IR: begin
            t_d.ir_sh = tap_pkg::IR_CAPTURE;
         end
         tap_pkg::TAP_SH_IR: begin
            t_d.ir_sh = {tdi_in, t_q.ir_sh[tap_pkg::IR_W-1:1]};
         end
         tap_pkg::TAP_UPD_IR: begin
            t_d.ir = t_q.ir_sh;
         end
         tap_pkg::TAP_CAP_DR: begin
            if (sel_chain) begin
               t_d.bs_sh = t_q.cap_s2;
            end else if (sel_id) begin
               t_d.id_sh = id_value;
            end else if (!sel_rst) begin
               t_d.byp = 1'b0;
            end
         end
         tap_pkg::TAP_SH_DR: begin
            if (sel_chain) begin
               t_d.bs_sh = {tdi_in, t_q.bs_sh[tap_pkg::CHAIN_W-1:1]};
            end else if (sel_id) begin
               t_d.id_sh = {tdi_in, t_q.id_sh[tap_pkg::ID_W-1:1]};
            end else if (sel_rst) begin
               t_d.rst_bit = tdi_in;
            end else begin
               t_d.byp = tdi_in;
            end
         end
         tap_pkg::TAP_UPD_DR: begin
            if (sel_chain) begin
               t_d.bs_upd = t_q.bs_sh;
            end
         end
         default: begin
         end
      endcase

      // power-on or disabled port: controller and registers to their reset values
      if (t_q.por_s2 || !tap_on) begin
         t_d.tap     = tap_pkg::TAP_RESET;
         t_d.ir      = tap_pkg::OP_IDCODE;
         t_d.ir_sh   = '0;
         t_d.byp     = 1'b0;
         t_d.id_sh   = '0;
         t_d.rst_bit = 1'b0;
         t_d.bs_sh   = '0;
         t_d.bs_upd  = '0;
      end
   end

   // the test clock runs alone; the chip clock may stand still
   always_ff @(posedge tck_in) begin
      t_q <= t_d;
   end

   // ----------------------------------------------------------------
   // test data out
   // ----------------------------------------------------------------
   always_comb begin
      tdo_oe_out = (t_q.tap == tap_pkg::TAP_SH_DR) || (t_q.tap == tap_pkg::TAP_SH_IR);
      if (t_q.tap == tap_pkg::TAP_SH_IR) begin
         tdo_out = t_q.ir_sh[0];
      end else if (sel_chain) begin
         tdo_out = t_q.bs_sh[0];
      end else if (sel_id) begin
         tdo_out = t_q.id_sh[0];
      end else if (sel_rst) begin
         tdo_out = t_q.rst_bit;
      end else begin
         tdo_out = t_q.byp;
      end
   end

   // ----------------------------------------------------------------
   // system clock domain: reset time-out after the test reset bit drops
   // ----------------------------------------------------------------
   assign tout_sel = clk_config_in ? tap_pkg::TOUT_W'(TOUT_SLOW_CYC - 1)
                                   : tap_pkg::TOUT_W'(TOUT_FAST_CYC - 1);

   always_comb begin
      s_d        = s_q;
      s_d.rst_s1 = t_q.rst_bit;
      s_d.rst_s2 = s_q.rst_s1;
      if (reset_in) begin
         s_d.busy = 1'b0;
         s_d.cnt  = '0;
      end else if (s_q.rst_s2) begin
         s_d.busy = 1'b1;
         s_d.cnt  = tout_sel;
      end else if (s_q.busy) begin
         if (s_q.cnt == '0) begin
            s_d.busy = 1'b0;
         end else begin
            s_d.cnt = s_q.cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      s_q <= s_d;
   end

endmodule

// [sim/tap_props.sv]
// tap_props: timing relations at the test port and on the chip reset output.
// assumes it is bound to boundary_scan_tap_logic and sees only its ports.
`timescale 1ns/10ps
module tap_props #(
   parameter int unsigned TOUT_FAST_CYC = 8,
   parameter int unsigned TOUT_SLOW_CYC = 20
) (
   // clocks and reset
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic tck_in,
   // configuration and port
   input wire logic tap_enable_fuse_in,
   input wire logic tap_disable_bit_in,
   input wire logic clk_config_in,
   input wire logic tms_in,
   // observed outputs
   input wire logic tdo_oe_out,
   input wire logic chip_reset_out
);
   // counts clk cycles the chip has been held in reset
   int unsigned hi_cnt_q;
   always_ff @(posedge clk_in) begin
      if (reset_in || !chip_reset_out) begin
         hi_cnt_q <= 0;
      end else begin
         hi_cnt_q <= hi_cnt_q + 1;
      end
   end

   a_fuse_off_quiet: assert property (@(posedge tck_in) disable iff (reset_in)
      !tap_enable_fuse_in [*3] |=> !tdo_oe_out) else $error("port active with fuse off");
   a_dis_bit_quiet: assert property (@(posedge tck_in) disable iff (reset_in)
      tap_disable_bit_in [*3] |=> !tdo_oe_out) else $error("port active with disable bit set");
   a_five_tms_reset: assert property (@(posedge tck_in) disable iff (reset_in)
      tms_in [*5] |=> !tdo_oe_out) else $error("five tms high did not reach reset");
   a_shift_stays: assert property (@(posedge tck_in) disable iff (reset_in)
      tdo_oe_out && !tms_in |=> tdo_oe_out) else $error("shift left with tms low");
   a_shift_ends: assert property (@(posedge tck_in) disable iff (reset_in)
      tdo_oe_out && tms_in |=> !tdo_oe_out) else $error("shift kept with tms high");
   a_shift_entry: assert property (@(posedge tck_in) disable iff (reset_in)
      $rose(tdo_oe_out) |-> $past(tms_in) == 1'b0) else $error("shift entered with tms high");
   a_reset_held: assert property (@(posedge clk_in) disable iff (reset_in)
      $rose(chip_reset_out) |=> chip_reset_out [*8]) else $error("chip reset dropped early");
   a_tout_fast: assert property (@(posedge clk_in) disable iff (reset_in)
      $fell(chip_reset_out) |-> hi_cnt_q >= TOUT_FAST_CYC) else $error("time-out too short");
   a_tout_slow: assert property (@(posedge clk_in) disable iff (reset_in)
      $fell(chip_reset_out) && clk_config_in |-> hi_cnt_q >= TOUT_SLOW_CYC) else $error("slow time-out short");

   c_reset_rise: cover property (@(posedge clk_in) $rose(chip_reset_out));
   c_reset_fall: cover property (@(posedge clk_in) $fell(chip_reset_out) && clk_config_in);
   c_shift: cover property (@(posedge tck_in) $rose(tdo_oe_out));
endmodule

bind boundary_scan_tap_logic tap_props #(
   .TOUT_FAST_CYC(TOUT_FAST_CYC),
   .TOUT_SLOW_CYC(TOUT_SLOW_CYC)
) tap_props_inst (
   .clk_in            (clk_in),
   .reset_in          (reset_in),
   .tck_in            (tck_in),
   .tap_enable_fuse_in(tap_enable_fuse_in),
   .tap_disable_bit_in(tap_disable_bit_in),
   .clk_config_in     (clk_config_in),
   .tms_in            (tms_in),
   .tdo_oe_out        (tdo_oe_out),
   .chip_reset_out    (chip_reset_out)
);

// [sim/jtag_host.sv]
// jtag_host: outside scan controller driving the test clock, tms and tdi.
// assumes tdo is settled half a test clock after each falling edge.
`timescale 1ns/10ps
module jtag_host (
   // test port
   output logic      tck_out,
   output logic      tms_out,
   output logic      tdi_out,
   input  wire logic tdo_in,
   input  wire logic tdo_oe_in
);
   logic oe_seen;
   initial begin
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b0;
      oe_seen = 1'b0;
   end

   // one test clock; tck stands low between frames
   task automatic step(input logic tms_v, input logic tdi_v, output logic tdo_v);
      tms_out = tms_v;
      tdi_out = tdi_v;
      #16;
      tdo_v = tdo_in;
      oe_seen = oe_seen | tdo_oe_in;
      tck_out = 1'b1;
      #16;
      tck_out = 1'b0;
   endtask

   task automatic reset5();
      logic d;
      for (int i = 0; i < 5; i++) step(1'b1, ~tdi_out, d);
      step(1'b0, ~tdi_out, d);
   endtask

   // idle to idle scan of n bits through ir or the selected data register
   task automatic scan(input logic is_ir, input int n, input logic [63:0] din, output logic [63:0] dout);
      logic d;
      dout = '0;
      step(1'b1, ~tdi_out, d);
      if (is_ir) step(1'b1, ~tdi_out, d);
      step(1'b0, ~tdi_out, d);
      step(1'b0, ~tdi_out, d);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], d);
         dout[i] = d;
      end
      step(1'b1, ~tdi_out, d);
      step(1'b0, ~tdi_out, d);
   endtask
endmodule

// [sim/tb.sv]
// tb: self-checking bench for boundary_scan_tap_logic.
// assumes jtag_host drives the test port and tap_props is bound to the design.
`timescale 1ns/10ps
`define CHECK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
   $display("[FAIL] t=%0t got %0h exp %0h", $time, (a), (b)); end end
module tb;
   logic                clk_in   = 1'b0;
   logic                reset_in = 1'b1;
   logic                fuse     = 1'b1;
   logic                dis_bit  = 1'b0;
   logic                clk_cfg  = 1'b0;
   tap_pkg::pin_drive_t sys_pins = 24'h3CA596;
   logic [3:0]          sys_ana  = 4'h5;
   logic [7:0]          pins_in  = 8'h6B;
   logic [3:0]          ana_obs  = 4'h9;
   logic                tck, tms, tdi, tdo, tdo_oe, chip_reset_out;
   tap_pkg::pin_drive_t port_pins_out;
   logic [3:0]          ana_ctl_out;
   logic [63:0]         d;
   int                  err_count  = 0;
   int                  n_compared = 0;
   // short time-outs keep the run small, yet outlast the tail of a scan
   localparam int       TOUT_FAST  = 40;
   localparam int       TOUT_SLOW  = 100;

   always #2 clk_in = ~clk_in;

   boundary_scan_tap_logic #(.TOUT_FAST_CYC(TOUT_FAST), .TOUT_SLOW_CYC(TOUT_SLOW)) boundary_scan_tap_logic_inst (
      .clk_in(clk_in), .reset_in(reset_in), .tap_enable_fuse_in(fuse), .tap_disable_bit_in(dis_bit),
      .clk_config_in(clk_cfg), .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo),
      .tdo_oe_out(tdo_oe), .sys_pins_in(sys_pins), .sys_ana_ctl_in(sys_ana), .port_pin_in(pins_in),
      .port_pins_out(port_pins_out), .ana_obs_in(ana_obs), .ana_ctl_out(ana_ctl_out),
      .chip_reset_out(chip_reset_out));
   jtag_host jtag_host_inst (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo), .tdo_oe_in(tdo_oe));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic tap_pkg::pin_drive_t drv(input logic [63:0] v);
      for (int i = 0; i < 8; i++) begin
         drv.dout[i] = v[4*i+1];
         drv.oe[i] = v[4*i+2];
         drv.pue[i] = v[4*i+3];
      end
   endfunction
   function automatic logic [7:0] ins(input logic [63:0] v);
      for (int i = 0; i < 8; i++) ins[i] = v[4*i];
   endfunction

   task automatic stop_test();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_idcode();
      jtag_host_inst.scan(1'b0, 32, 64'h0, d);
      `CHECK(d[31:0], {tap_pkg::ID_VERSION, tap_pkg::ID_PART, tap_pkg::ID_MAKER, tap_pkg::ID_LSB})
   endtask

   task automatic t_bypass();
      logic [3:0] codes [4];
      codes = '{4'hF, 4'h3, 4'h7, 4'hE};
      foreach (codes[k]) begin
         jtag_host_inst.scan(1'b1, 4, {60'h0, codes[k]}, d);
         `CHECK(d[3:0], tap_pkg::IR_CAPTURE)
         jtag_host_inst.scan(1'b0, 2, 64'h3, d);
         `CHECK(d[1:0], 2'h2)
      end
   endtask

   task automatic t_boundary();
      logic [63:0] p;
      logic [63:0] q;
      p = 64'h93C5AA5C3;
      q = 64'h6C3A55A3C;
      jtag_host_inst.scan(1'b1, 4, 64'h2, d);
      jtag_host_inst.scan(1'b0, 40, p, d);
      `CHECK(ins(d), pins_in)
      `CHECK(d[39:36], ana_obs)
      `CHECK(port_pins_out, sys_pins)
      `CHECK(ana_ctl_out, sys_ana)
      jtag_host_inst.scan(1'b1, 4, 64'h0, d);
      `CHECK(port_pins_out, drv(p))
      `CHECK(ana_ctl_out, p[35:32])
      jtag_host_inst.scan(1'b0, 40, q, d);
      `CHECK(ins(d), pins_in)
      `CHECK(drv(d), drv(p))
      `CHECK(port_pins_out, drv(q))
      `CHECK(ana_ctl_out, q[35:32])
   endtask

   task automatic t_chip_reset(input logic cfg);
      int n;
      int tout;
      tout = cfg ? TOUT_SLOW : TOUT_FAST;
      @(posedge clk_in) clk_cfg <= cfg;
      jtag_host_inst.scan(1'b1, 4, 64'hC, d);
      jtag_host_inst.scan(1'b0, 1, 64'h1, d);
      `CHECK(chip_reset_out, 1'b1)
      `CHECK(port_pins_out, tap_pkg::pin_drive_t'(24'h0))
      jtag_host_inst.scan(1'b0, 2, 64'h1, d);
      `CHECK(d[1:0], 2'h3)
      for (n = 0; n < 200 && chip_reset_out !== 1'b0; n++) @(posedge clk_in);
      #1;
      `CHECK(chip_reset_out, 1'b0)
      // the scan ends 2.5 test clocks, 20 chip clocks, after the shift edge that clears the bit
      `CHECK((n + 20 >= tout) && (n + 20 <= tout + 5), 1'b1)
      `CHECK(port_pins_out, sys_pins)
   endtask

   task automatic t_disabled();
      for (int k = 0; k < 2; k++) begin
         @(posedge clk_in) begin
            fuse <= (k != 0);
            dis_bit <= (k != 0);
         end
         jtag_host_inst.oe_seen = 1'b0;
         jtag_host_inst.reset5();
         jtag_host_inst.scan(1'b0, 32, 64'h0, d);
         `CHECK(jtag_host_inst.oe_seen, 1'b0)
         @(posedge clk_in) begin
            fuse <= 1'b1;
            dis_bit <= 1'b0;
         end
         jtag_host_inst.reset5();
         t_idcode();
      end
   endtask

   initial begin
      @(posedge clk_in);
      jtag_host_inst.reset5();
      @(posedge clk_in) reset_in <= 1'b0;
      jtag_host_inst.reset5();
      t_idcode();
      t_bypass();
      t_boundary();
      t_chip_reset(1'b0);
      t_chip_reset(1'b1);
      t_disabled();
      stop_test();
   end

   initial begin
      #200000;
      err_count++;
      stop_test();
   end
endmodule
